// File: testbench.sv
`timescale 1ns/1ps
`include "tws_params.svh"

module testbench;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [7:0] rdata;
    logic sck_o, sck_oe, so_o, so_oe, busy, done_flag, si, sck_drv, sck_w;
    logic ckp = 1'b0, dap = 1'b0, lsb = 1'b0, arm = 1'b0, go = 1'b0;
    logic [7:0] peer_tx = 8'h00;
    logic [7:0] got;
    logic [7:0] b;
    int err_total = 0;
    int n_compared = 0;

    // Clock line: the port drives it as master, the peer otherwise
    assign sck_w = sck_oe ? sck_o : sck_drv;

    tws_serial_port #(.DIV_W(7)) u_dut (.core_clk(core_clk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .sck_i(sck_w),
        .sck_o(sck_o), .sck_oe(sck_oe), .si_i(si), .so_o(so_o), .so_oe(so_oe), .busy(busy),
        .done_flag(done_flag));
    tws_peer_model u_peer (.sck(sck_w), .so(so_o), .ckp(ckp), .dap(dap), .lsb(lsb),
        .arm(arm), .go(go), .tx_byte(peer_tx), .sck_drv(sck_drv), .si(si), .got(got));

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    // ----------------------------------------
    // Bus tasks and checks
    // ----------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_compared++;
        if (seen !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
            err_total++;
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
        @(posedge core_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        @(negedge core_clk);
        chk(what, exp, rdata);
    endtask
    // Bounded wait; registers untouched meanwhile
    task automatic wait_idle;
        int n;
        n = 0;
        // Let the start edge settle so busy is seen after it rises
        @(negedge core_clk);
        while (busy !== 1'b0 && n < 4000) begin
            @(negedge core_clk);
            n++;
        end
        chk("busy_end", 8'h00, {7'h00, busy});
    endtask
    task automatic load(input logic [7:0] v);
        // Byte settles on the peer's port before its arm edge reads it
        peer_tx = v;
        #1 arm = 1'b1;
        #1 arm = 1'b0;
    endtask
    task automatic results;
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        err_total++;
        results();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        rd(`TWS_OFF_MODE, 8'h00, "mode_rst");
        rd(`TWS_OFF_CLKSEL, 8'h00, "cs_rst");
        rd(16'hFF90, 8'h00, "unmapped");
        chk("pins_off", 8'h00, {6'h00, sck_oe, so_oe});
        // Master duplex in all four timing types, both bit orders
        for (int t = 0; t < 4; t++) begin
            ckp = t[1];
            dap = t[0];
            lsb = t[0] ^ t[1];
            b = 8'hA5 + t[7:0];
            wr(`TWS_OFF_CLKSEL, {3'h0, ckp, dap, 3'h2});
            wr(`TWS_OFF_MODE, {2'h1, 1'b0, lsb, 4'h0});
            wr(`TWS_OFF_MODE, {2'h3, 1'b0, lsb, 4'h0});
            load(8'h3C ^ t[7:0]);
            wr(`TWS_OFF_TXBUF, b);
            @(negedge core_clk);
            chk("busy_start", 8'h01, {7'h00, busy});
            wait_idle();
            rd(`TWS_OFF_FLAG, 8'h01, "done");
            chk("peer_got", b, got);
            chk("last_bit", {7'h00, lsb ? b[7] : b[0]}, {7'h00, so_o});
            rd(`TWS_OFF_MODE, {2'h3, 1'b0, lsb, 4'h0}, "mode_idle");
            rd(`TWS_OFF_SHIFT, 8'h3C ^ t[7:0], "rx_byte");
            wr(`TWS_OFF_FLAG, 8'h00);
            wr(`TWS_OFF_MODE, 8'h00);
        end
        // Slave frame on the peer's link clock
        ckp = 1'b0;
        dap = 1'b0;
        lsb = 1'b0;
        wr(`TWS_OFF_CLKSEL, 8'h07);
        wr(`TWS_OFF_MODE, 8'hC0);
        @(negedge core_clk);
        chk("slave_oe", 8'h00, {7'h00, sck_oe});
        load(8'h96);
        wr(`TWS_OFF_TXBUF, 8'h5A);
        go = 1'b1;
        wait_idle();
        go = 1'b0;
        chk("slave_got", 8'h5A, got);
        rd(`TWS_OFF_SHIFT, 8'h96, "slave_rx");
        wr(`TWS_OFF_FLAG, 8'h00);
        // Disable clears the shifter; a stopped read starts nothing
        wr(`TWS_OFF_MODE, 8'h00);
        rd(`TWS_OFF_SHIFT, 8'h00, "shift_clr");
        // Master receive-only, then abort mid-frame
        wr(`TWS_OFF_CLKSEL, 8'h03);
        wr(`TWS_OFF_MODE, 8'h80);
        load(8'hC3);
        rd(`TWS_OFF_SHIFT, 8'h00, "rx_start");
        wait_idle();
        wr(`TWS_OFF_FLAG, 8'hFF);
        rd(`TWS_OFF_FLAG, 8'h01, "flag_w1");
        wr(`TWS_OFF_FLAG, 8'h00);
        load(8'h3E);
        rd(`TWS_OFF_SHIFT, 8'hC3, "rx_data");
        chk("rx_busy", 8'h01, {7'h00, busy});
        repeat (6) @(posedge core_clk);
        wr(`TWS_OFF_MODE, 8'h00);
        rd(`TWS_OFF_FLAG, 8'h00, "abort_flag");
        rd(`TWS_OFF_MODE, 8'h00, "abort_mode");
        rd(`TWS_OFF_SHIFT, 8'h00, "abort_shift");
        chk("pins_end", 8'h00, {6'h00, sck_oe, so_oe});
        results();
    end
endmodule

// File: tws_params.svh
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define TWS_ADDR_W 16
`define TWS_OFF_MODE 16'hFF80
`define TWS_OFF_CLKSEL 16'hFF81
`define TWS_OFF_TXBUF 16'hFF82
`define TWS_OFF_SHIFT 16'hFF83
`define TWS_OFF_FLAG 16'hFF84

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TWS_MODE_EN 7
`define TWS_MODE_TRMD 6
`define TWS_MODE_DIR 4
`define TWS_MODE_BUSY 0
`define TWS_CS_CKP 4
`define TWS_CS_DAP 3
`define TWS_FLAG_DONE 0

// ----------------------------------------
// Values and counts
// ----------------------------------------
`define TWS_RST_BYTE 8'h00
`define TWS_CKS_SLAVE 3'h7
`define TWS_EDGE_LAST 4'hF
`define TWS_DIV_W 7

`endif

// File: tws_peer_model.sv
`timescale 1ns/1ps

// Peripheral on the far side of the link; launches and captures on opposite edges
module tws_peer_model (
    input wire logic sck,
    input wire logic so,
    input wire logic ckp,
    input wire logic dap,
    input wire logic lsb,
    input wire logic arm,
    input wire logic go,
    input wire logic [7:0] tx_byte,
    output logic sck_drv,
    output logic si,
    output logic [7:0] got
);
    int idx; // Next bit to launch
    int ncap; // Bits captured

    // Bit i of the outgoing byte in the chosen order
    function automatic logic pick(input logic [7:0] v, input int i);
        return lsb ? v[i] : v[7 - i];
    endfunction

    // New byte: first bit ready early for the strobe-launch phase
    always @(posedge arm) begin
        got = 8'h00;
        ncap = 0;
        si = pick(tx_byte, 0);
        idx = dap ? 1 : 0;
    end

    // Normalised level idles high; launch when it equals the phase bit
    always @(sck) begin
        if ((sck ^ ckp) == dap) begin
            if (idx < 8) begin
                si = pick(tx_byte, idx);
                idx++;
            end
        end else begin
            got = lsb ? {so, got[7:1]} : {got[6:0], so};
            ncap++;
            // Hold time over: the line stops showing the last bit
            if (ncap == 8) si <= #20 ~si;
        end
    end

    // Slave frames: sixteen half periods of 62.5 ns, still in between
    initial sck_drv = 1'b1;
    always @(posedge go) begin
        sck_drv = ~ckp;
        #3.1;
        repeat (16) #62.5 sck_drv = ~sck_drv;
    end
endmodule

// File: tws_pkg.sv
package tws_pkg;

    // Transfer sequencer states, Gray coded along idle -> first -> shift
    typedef enum logic [1:0] {
        tws_idle = 2'b00,
        tws_first = 2'b01,
        tws_shift = 2'b11
    } tws_state_t;

endpackage

// File: tws_sck_unit.sv
`timescale 1ns/1ps
`include "tws_params.svh"

// Serial clock source: divider in master mode, pin edge finder in slave mode.
// Levels are normalised so that the idle level is always high.
module tws_sck_unit #(
    parameter int DIV_W = `TWS_DIV_W
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic master,
    input wire logic [2:0] cks,
    input wire logic ckp,
    input wire logic sck_pin,
    output logic lead,
    output logic trail,
    output logic lvl
);

    // ----------------------------------------
    // Pin synchroniser
    // ----------------------------------------
    logic s1; // First stage, read only by s2
    logic s2; // Second stage
    logic s3; // Previous sample for edge finding
    logic norm2; // Normalised current level
    logic norm3; // Normalised previous level

    // Three flops: two for metastability, one for the edge compare
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= sck_pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Polarity folded in so idle reads high
    assign norm2 = s2 ^ ckp;
    assign norm3 = s3 ^ ckp;

    // ----------------------------------------
    // Master divider
    // ----------------------------------------
    logic [DIV_W-1:0] cnt; // Half-period counter
    logic [DIV_W-1:0] half; // Half period in core cycles
    logic tick; // Half period elapsed
    logic mlvl; // Generated normalised level

    // Half period is 2^cks core cycles: clock is core/2^(cks+1)
    assign half = DIV_W'(1) << cks;
    assign tick = (cnt == half - DIV_W'(1));

    // Divider runs only during a master transfer; otherwise parks at idle
    always_ff @(posedge core_clk) begin
        if (!nrst || !run || !master) begin
            cnt <= '0;
            mlvl <= 1'b1;
        end else if (tick) begin
            cnt <= '0;
            mlvl <= ~mlvl;
        end else begin
            cnt <= cnt + DIV_W'(1);
        end
    end

    // Lead is the falling normalised edge, trail the rising one
    assign lead = run & (master ? (tick & mlvl) : (norm3 & ~norm2));
    assign trail = run & (master ? (tick & ~mlvl) : (~norm3 & norm2));
    assign lvl = mlvl;

endmodule

// File: tws_serial_port.sv
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "tws_params.svh"

// Contract
// - Enable clear stops transfers, frees pins
// - Enable clear resets busy and shifter
// - Mode register resets to zero
// - Exactly eight bits per transfer, clocked
// - Transmit mode: buffer write starts duplex transfer
// - Receive mode: shifter read starts reception
// - Busy flag set on start
// - Eighth bit sets done flag, clears busy
// - Link has clock, out, in lines
// - Phase zero: launch first edge, load next
// - Later bits launch from shifter on each launch edge
// - Phase one: first bit launched at strobe
// - Receive mode holds output low
// - Output keeps last bit after transfer
module tws_serial_port #(
    parameter int DIV_W = `TWS_DIV_W
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [`TWS_ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe,
    output logic busy,
    output logic done_flag
);

    // ----------------------------------------
    // Control state
    // ----------------------------------------
    logic en; // Port enable
    logic trmd; // Transmit mode
    logic dir; // LSB first when high
    logic ckp; // Clock polarity
    logic dap; // Data phase
    logic [2:0] cks; // Clock source select
    logic [7:0] txbuf; // Transmit buffer
    logic [7:0] shreg; // Serial shift register
    logic so_latch; // Serial output latch
    logic [3:0] ec; // Serial clock edges seen
    tws_pkg::tws_state_t state; // Sequencer state

    // ----------------------------------------
    // Input synchroniser for the data pin
    // ----------------------------------------
    logic si_s1; // First stage, read only by si_s2
    logic si_s2; // Usable sample

    // Two flops before any logic looks at the data pin
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            si_s1 <= 1'b0;
            si_s2 <= 1'b0;
        end else begin
            si_s1 <= si_i;
            si_s2 <= si_s1;
        end
    end

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    logic wr_mode; // Mode register write
    logic wr_cs; // Clock selection write
    logic wr_tx; // Transmit buffer write
    logic wr_flag; // Done flag write
    logic rd_sh; // Shift register read

    assign wr_mode = wr_stb && (addr == `TWS_OFF_MODE);
    assign wr_cs = wr_stb && (addr == `TWS_OFF_CLKSEL);
    assign wr_tx = wr_stb && (addr == `TWS_OFF_TXBUF);
    assign wr_flag = wr_stb && (addr == `TWS_OFF_FLAG);
    assign rd_sh = rd_stb && (addr == `TWS_OFF_SHIFT);

    // ----------------------------------------
    // Transfer triggers
    // ----------------------------------------
    logic start_tx; // Duplex start
    logic start_rx; // Receive-only start
    logic start; // Any start
    logic master; // Device makes the clock

    // Triggers while busy are dropped; software must wait anyway
    assign start_tx = wr_tx & en & trmd & ~busy;
    assign start_rx = rd_sh & en & ~trmd & ~busy;
    assign start = start_tx | start_rx;

    // Only the all-ones select makes us a slave
    assign master = (cks != `TWS_CKS_SLAVE);

    // ----------------------------------------
    // Serial clock source
    // ----------------------------------------
    logic lead; // Falling normalised edge
    logic trail; // Rising normalised edge
    logic mlvl; // Master normalised level

    tws_sck_unit #(
        .DIV_W(DIV_W)
    ) u_sck (
        .core_clk(core_clk),
        .nrst(nrst),
        .run(busy),
        .master(master),
        .cks(cks),
        .ckp(ckp),
        .sck_pin(sck_i),
        .lead(lead),
        .trail(trail),
        .lvl(mlvl)
    );

    // ----------------------------------------
    // Edge roles and bit helpers
    // ----------------------------------------
    logic samp; // Capture edge
    logic launch; // Output edge
    logic edge_any; // Either edge
    logic last; // Sixteenth edge
    logic [7:0] src; // Byte being shifted

    // Phase picks which edge captures and which launches
    assign samp = dap ? lead : trail;
    assign launch = dap ? trail : lead;
    assign edge_any = lead | trail;
    assign last = edge_any && (ec == `TWS_EDGE_LAST);

    // Until the first capture, data still comes from the buffer
    assign src = (state == tws_pkg::tws_first) ? txbuf : shreg;

    // Bit leaving first in the chosen order
    function automatic logic out_bit(input logic [7:0] x, input logic lsb);
        out_bit = lsb ? x[0] : x[7];
    endfunction

    // Shift one place, inserting the captured bit
    function automatic logic [7:0] shift_in(input logic [7:0] x, input logic b,
                                            input logic lsb);
        shift_in = lsb ? {b, x[7:1]} : {x[6:0], b};
    endfunction

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------

    // Mode register; the busy bit is read-only and ignored here
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            en <= 1'b0;
            trmd <= 1'b0;
            dir <= 1'b0;
        end else if (wr_mode) begin
            en <= wdata[`TWS_MODE_EN];
            trmd <= wdata[`TWS_MODE_TRMD];
            dir <= wdata[`TWS_MODE_DIR];
        end
    end

    // Clock selection; written while enabled is taken as is
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ckp <= 1'b0;
            dap <= 1'b0;
            cks <= 3'h0;
        end else if (wr_cs) begin
            ckp <= wdata[`TWS_CS_CKP];
            dap <= wdata[`TWS_CS_DAP];
            cks <= wdata[2:0];
        end
    end

    // Transmit buffer
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            txbuf <= `TWS_RST_BYTE;
        end else if (wr_tx) begin
            txbuf <= wdata;
        end
    end

    // ----------------------------------------
    // Transfer sequencer
    // ----------------------------------------

    // Disable clears busy and edge count at once; the reset is taken
    // synchronously here, so it lands on the next core clock edge
    always_ff @(posedge core_clk) begin
        if (!nrst || !en) begin
            state <= tws_pkg::tws_idle;
            busy <= 1'b0;
            ec <= 4'h0;
        end else begin
            case (state)
                tws_pkg::tws_idle: begin
                    if (start) begin
                        state <= tws_pkg::tws_first;
                        busy <= 1'b1;
                        ec <= 4'h0;
                    end
                end
                tws_pkg::tws_first: begin
                    if (edge_any) begin
                        ec <= ec + 4'h1;
                    end
                    if (samp) begin
                        state <= tws_pkg::tws_shift;
                    end
                end
                tws_pkg::tws_shift: begin
                    if (edge_any) begin
                        ec <= ec + 4'h1;
                    end
                    if (last) begin
                        state <= tws_pkg::tws_idle;
                        busy <= 1'b0;
                        ec <= 4'h0;
                    end
                end
                default: begin
                    state <= tws_pkg::tws_idle;
                    busy <= 1'b0;
                    ec <= 4'h0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Shift register
    // ----------------------------------------

    // Capture edge: first one loads the buffer and shifts in one go
    always_ff @(posedge core_clk) begin
        if (!nrst || !en) begin
            shreg <= `TWS_RST_BYTE;
        end else if (busy && samp) begin
            shreg <= shift_in(src, si_s2, dir);
        end
    end

    // ----------------------------------------
    // Output latch
    // ----------------------------------------

    // Phase one takes the first bit from the strobe's own data, since the
    // buffer only lands on that same edge; phase zero waits
    // for the first launch edge. No launch after the final capture.
    always_ff @(posedge core_clk) begin
        if (!nrst || !en) begin
            so_latch <= 1'b0;
        end else if (start && dap) begin
            so_latch <= out_bit(start_tx ? wdata : txbuf, dir);
        end else if (busy && launch && !last) begin
            so_latch <= out_bit(src, dir);
        end
    end

    // ----------------------------------------
    // Done flag
    // ----------------------------------------

    // Set on completion; software writes zero to clear; the set wins
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            done_flag <= 1'b0;
        end else if (busy && last) begin
            done_flag <= 1'b1;
        end else if (wr_flag && !wdata[`TWS_FLAG_DONE]) begin
            done_flag <= 1'b0;
        end
    end

    // ----------------------------------------
    // Pins
    // ----------------------------------------

    // Clock driven only as master while enabled; idle level from polarity
    assign sck_o = mlvl ^ ckp;
    assign sck_oe = en & master;

    // Receive mode pins the output low; disabled phase-one shows the
    // buffer's first bit, as the latch would pick it up on start
    always_comb begin
        if (!trmd) begin
            so_o = 1'b0;
        end else if (!en && dap) begin
            so_o = out_bit(txbuf, dir);
        end else begin
            so_o = so_latch;
        end
    end

    // Output pin released to port use in stop or receive mode
    assign so_oe = en & trmd;

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    logic [7:0] rd_val; // Selected read value

    // Unmapped addresses read zero
    always_comb begin
        rd_val = 8'h00;
        case (addr)
            `TWS_OFF_MODE: begin
                rd_val[`TWS_MODE_EN] = en;
                rd_val[`TWS_MODE_TRMD] = trmd;
                rd_val[`TWS_MODE_DIR] = dir;
                rd_val[`TWS_MODE_BUSY] = busy;
            end
            `TWS_OFF_CLKSEL: begin
                rd_val[`TWS_CS_CKP] = ckp;
                rd_val[`TWS_CS_DAP] = dap;
                rd_val[2:0] = cks;
            end
            `TWS_OFF_TXBUF: begin
                rd_val = txbuf;
            end
            `TWS_OFF_SHIFT: begin
                rd_val = shreg;
            end
            `TWS_OFF_FLAG: begin
                rd_val[`TWS_FLAG_DONE] = done_flag;
            end
            default: begin
                rd_val = 8'h00;
            end
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (rd_stb) begin
            rdata <= rd_val;
        end else begin
            rdata <= 8'h00;
        end
    end

endmodule

// File: tws_serial_port_checker.sv
`timescale 1ns/1ps
`include "tws_params.svh"

// Watches pins and register bus; shadows mode and clock selection
module tws_serial_port_checker #(
    parameter int DIV_W = 7
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] rdata,
    input wire logic sck_i,
    input wire logic sck_o,
    input wire logic sck_oe,
    input wire logic si_i,
    input wire logic so_o,
    input wire logic so_oe,
    input wire logic busy,
    input wire logic done_flag
);
    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    logic [7:0] mode_q; // Mode as last written
    logic [7:0] cs_q; // Clock selection as last written
    logic [4:0] edge_cnt; // Clock pin changes since start
    logic sck_d; // Clock pin one cycle back

    // Shadow software writes; the busy bit is ignored
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            mode_q <= 8'h00;
            cs_q <= 8'h00;
        end else if (wr_stb && addr == `TWS_OFF_MODE) begin
            mode_q <= wdata;
        end else if (wr_stb && addr == `TWS_OFF_CLKSEL) begin
            cs_q <= wdata;
        end
    end

    // Count pin edges per transfer; wraps only on long idle toggling
    always_ff @(posedge core_clk) begin
        sck_d <= sck_o;
        if (!nrst || $rose(busy)) begin
            edge_cnt <= 5'h00;
        end else if (sck_o != sck_d) begin
            edge_cnt <= edge_cnt + 5'h01;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_tx_start:
    assert property (wr_stb && addr == `TWS_OFF_TXBUF && mode_q[7] && mode_q[6] && !busy
        |=> busy) else $error("buffer write did not start a transfer");
    a_rx_start:
    assert property (rd_stb && addr == `TWS_OFF_SHIFT && mode_q[7] && !mode_q[6] && !busy
        |=> busy) else $error("shift read did not start a reception");
    a_done_on_end:
    assert property ($fell(busy) && mode_q[7] |-> done_flag)
        else $error("transfer ended without done flag");
    a_rx_out_low:
    assert property (!mode_q[6] |-> !so_o && !so_oe) else $error("output not low in receive mode");
    a_stop_pins:
    assert property (!mode_q[7] |-> !sck_oe && !so_oe) else $error("pins driven while stopped");
    a_abort_busy:
    assert property ($fell(mode_q[7]) |=> !busy [*3]) else $error("disable left busy set");
    a_edge_count:
    assert property ($fell(busy) && mode_q[7] && cs_q[2:0] != 3'h7 |-> ##2 edge_cnt == 5'h10)
        else $error("master transfer did not give sixteen clock edges");
    a_idle_level:
    assert property (mode_q[7] && cs_q[2:0] != 3'h7 && !busy && !$past(busy) && !$past(busy, 2)
        |-> sck_o == !cs_q[4]) else $error("clock idle level wrong");
    a_last_hold:
    assert property ($fell(busy) && mode_q[7] && mode_q[6] |=> $stable(so_o) [*3])
        else $error("output did not hold last bit");
endmodule

bind tws_serial_port tws_serial_port_checker #(.DIV_W(DIV_W)) u_chk (.core_clk(core_clk),
    .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe), .si_i(si_i), .so_o(so_o), .so_oe(so_oe),
    .busy(busy), .done_flag(done_flag));
